// ### logic/dpcio_front.sv
`default_nettype none
//Contract
// RULE1 - async mode: every emitted bit lasts 372 link clock periods
// RULE2 - sync mode: incoming bits sampled on rising serial clock edge
// RULE3 - sync mode: outgoing bits updated on falling serial clock edge
// RULE4 - reset activation in async mode sends the 64-bit reset answer; code starts it on the rising edge of card_rst_i (reset release)
// RULE5 - no reset answer at all while in sync two-wire mode
// RULE6 - reset input is pulled inactive internally when left open
// RULE7 - data line is only pulled low or released, never driven high
// RULE8 - up to 15 addressed devices; respond only to own address
// RULE9 - host changes data only while serial clock is low
// RULE10 - falling data with clock high is a start, precedes commands
// RULE11 - rising data with clock high is a stop; enter standby
// RULE12 - acknowledge each received byte by pulling low on ninth clock; code sends no ack for a data byte while the receive buffer is full
// RULE13 - reset answer sent first byte first, then back to idle
module dpcio_front
	import dpcio_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        link_clk_i,
	input  wire logic        card_rst_i,
	input  wire logic        data_i,
	input  wire logic        mode_async_i,
	input  wire logic [3:0]  dev_addr_i,
	input  wire logic [63:0] atr_value_i,
	input  wire logic [7:0]  tx_data_i,
	input  wire logic        tx_valid_i,
	output logic             tx_ready_o,
	output logic [7:0]       rx_data_o,
	output logic             rx_valid_o,
	input  wire logic        rx_ready_i,
	output logic             data_o,
	output logic             data_oe_o,
	output logic             rst_pull_en_o
);
	// ----------------------------------------------------------------
	// pin synchronisers and edge finding
	// ----------------------------------------------------------------
	logic [PIN_N-1:0] pin_s1_ff;
	logic [PIN_N-1:0] pin_s2_ff;
	logic [PIN_N-1:0] pin_d_ff;
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			{pin_s1_ff, pin_s2_ff, pin_d_ff} <= 12'hFFF;
		else
		begin
			pin_s1_ff <= {mode_async_i, card_rst_i, data_i, link_clk_i};
			pin_s2_ff <= pin_s1_ff;
			pin_d_ff  <= pin_s2_ff;
		end
	end
	logic clk_rise;
	logic clk_fall;
	logic clk_high;
	logic dat_rise;
	logic dat_fall;
	logic rst_rise;
	logic is_async;
	logic start_cond;
	logic stop_cond;
	assign clk_rise = pin_s2_ff[PIN_CLK] & ~pin_d_ff[PIN_CLK];
	assign clk_fall = ~pin_s2_ff[PIN_CLK] & pin_d_ff[PIN_CLK];
	assign clk_high = pin_s2_ff[PIN_CLK] & pin_d_ff[PIN_CLK];
	assign dat_rise = pin_s2_ff[PIN_DAT] & ~pin_d_ff[PIN_DAT];
	assign dat_fall = ~pin_s2_ff[PIN_DAT] & pin_d_ff[PIN_DAT];
	assign rst_rise = pin_s2_ff[PIN_RST] & ~pin_d_ff[PIN_RST];
	assign is_async = pin_s2_ff[PIN_MODE];
	// RULE10 start detect
	assign start_cond = ~is_async & clk_high & dat_fall;
	// RULE11 stop detect
	assign stop_cond = ~is_async & clk_high & dat_rise;
	// RULE6 internal pull-up
	assign rst_pull_en_o = 1'b1;
	// RULE7 open-drain only
	assign data_o = 1'b0;
	// ----------------------------------------------------------------
	// two-entry receive buffer
	// ----------------------------------------------------------------
	logic [7:0] buf_ff [2];
	logic       wr_ptr_ff;
	logic       rd_ptr_ff;
	logic [1:0] fill_ff;
	logic       push;
	logic       pop;
	logic       buf_full;
	logic [7:0] shift_ff;
	assign buf_full   = fill_ff[1];
	assign rx_valid_o = |fill_ff;
	assign rx_data_o  = buf_ff[rd_ptr_ff];
	assign pop        = rx_valid_o & rx_ready_i;
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			buf_ff[0] <= 8'h00;
			buf_ff[1] <= 8'h00;
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			fill_ff   <= 2'h0;
		end
		else
		begin
			if (push)
			begin
				buf_ff[wr_ptr_ff] <= shift_ff;
				wr_ptr_ff         <= ~wr_ptr_ff;
			end
			if (pop)
				rd_ptr_ff <= ~rd_ptr_ff;
			fill_ff <= 2'(fill_ff + {1'b0, push} - {1'b0, pop});
		end
	end
	// ----------------------------------------------------------------
	// elementary_bit_time counter
	// ----------------------------------------------------------------
	dpcio_state_t state_ff;
	logic [8:0]   etu_cnt_ff;
	logic         etu_tick;
	// RULE1 bit length
	assign etu_tick = (state_ff == ST_ATR) & clk_rise & (etu_cnt_ff == ETU_LAST);
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			etu_cnt_ff <= 9'h000;
		else if (state_ff != ST_ATR)
			etu_cnt_ff <= 9'h000;
		else if (clk_rise)
			etu_cnt_ff <= etu_tick ? 9'h000 : 9'(etu_cnt_ff + 9'h001);
	end
	// ----------------------------------------------------------------
	// protocol state machine
	// ----------------------------------------------------------------
	logic [3:0] bit_cnt_ff;
	logic [2:0] atr_byte_ff;
	logic       addr_hit;
	logic       is_read;
	logic       ack_phase;
	logic       byte_end;
	logic       nack_ff;
	logic [7:0] atr_byte;
	logic       atr_bit;
	// RULE8 own address only
	assign addr_hit  = (shift_ff[ADDR_MSB:ADDR_LSB] == dev_addr_i) & (dev_addr_i != ADDR_NONE);
	assign is_read   = shift_ff[RW_BIT];
	assign ack_phase = clk_fall & (bit_cnt_ff == BIT_ACK);
	assign byte_end  = clk_fall & (bit_cnt_ff == BIT_END);
	assign push      = (state_ff == ST_WR) & ack_phase & ~buf_full;
	assign tx_ready_o = byte_end & ~nack_ff & tx_valid_i
		& ((state_ff == ST_RD) | ((state_ff == ST_CMD) & addr_hit & is_read));
	// RULE13 first byte first
	assign atr_byte = atr_value_i[{atr_byte_ff, 3'h0} +: 8];
	always_comb
	begin
		atr_bit = 1'b1;
		if (bit_cnt_ff == CHAR_START)
			atr_bit = 1'b0;
		else if (bit_cnt_ff < CHAR_PARITY)
			atr_bit = atr_byte[3'(bit_cnt_ff - 4'h1)];
		else if (bit_cnt_ff == CHAR_PARITY)
			atr_bit = ^atr_byte;
	end
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_ff    <= ST_IDLE;
			bit_cnt_ff  <= 4'h0;
			atr_byte_ff <= 3'h0;
			shift_ff    <= 8'h00;
			nack_ff     <= 1'b0;
			data_oe_o   <= 1'b0;
		end
		else if (is_async & rst_rise)
		begin
			// RULE4 reset answer start
			state_ff    <= ST_ATR;
			bit_cnt_ff  <= CHAR_START;
			atr_byte_ff <= 3'h0;
			data_oe_o   <= 1'b1;
		end
		else if (start_cond)
		begin
			state_ff   <= ST_CMD;
			bit_cnt_ff <= 4'h0;
			nack_ff    <= 1'b0;
			data_oe_o  <= 1'b0;
		end
		else if (stop_cond)
		begin
			// RULE11 standby on stop
			state_ff  <= ST_IDLE;
			data_oe_o <= 1'b0;
		end
		else
		begin
			unique case (state_ff)
				ST_IDLE: data_oe_o <= 1'b0;
				ST_ATR:
				begin
					// RULE5 async only
					if (!is_async)
					begin
						state_ff  <= ST_IDLE;
						data_oe_o <= 1'b0;
					end
					else if (etu_tick)
					begin
						if (bit_cnt_ff != CHAR_LAST)
							bit_cnt_ff <= 4'(bit_cnt_ff + 4'h1);
						else if (atr_byte_ff == ATR_LAST_BYTE)
						begin
							// RULE13 back to idle
							state_ff  <= ST_IDLE;
							data_oe_o <= 1'b0;
						end
						else
						begin
							atr_byte_ff <= 3'(atr_byte_ff + 3'h1);
							bit_cnt_ff  <= CHAR_START;
						end
					end
					else
						// RULE7 low or released
						data_oe_o <= ~atr_bit;
				end
				ST_CMD, ST_WR:
				begin
					if (clk_rise && bit_cnt_ff < BIT_ACK)
					begin
						// RULE2 sample on rise
						shift_ff   <= {shift_ff[6:0], pin_s2_ff[PIN_DAT]};
						bit_cnt_ff <= 4'(bit_cnt_ff + 4'h1);
					end
					else if (clk_rise && bit_cnt_ff == BIT_ACK)
						bit_cnt_ff <= BIT_END;
					else if (ack_phase)
						// RULE12 ninth clock acknowledge
						data_oe_o <= (state_ff == ST_WR) ? ~buf_full : addr_hit;
					else if (byte_end)
					begin
						bit_cnt_ff <= 4'h0;
						data_oe_o  <= 1'b0;
						if (state_ff == ST_CMD)
						begin
							if (!addr_hit)
								state_ff <= ST_IDLE;
							else if (is_read)
							begin
								state_ff  <= ST_RD;
								shift_ff  <= tx_valid_i ? tx_data_i : IDLE_BYTE;
								data_oe_o <= tx_valid_i ? ~tx_data_i[7] : 1'b0;
							end
							else
								state_ff <= ST_WR;
						end
					end
				end
				ST_RD:
				begin
					if (clk_rise && bit_cnt_ff < BIT_ACK)
						bit_cnt_ff <= 4'(bit_cnt_ff + 4'h1);
					else if (clk_rise && bit_cnt_ff == BIT_ACK)
					begin
						nack_ff    <= pin_s2_ff[PIN_DAT];
						bit_cnt_ff <= BIT_END;
					end
					else if (clk_fall && bit_cnt_ff != 4'h0 && bit_cnt_ff < BIT_ACK)
					begin
						// RULE3 update on fall
						shift_ff  <= {shift_ff[6:0], 1'b1};
						data_oe_o <= ~shift_ff[6];
					end
					else if (ack_phase)
						data_oe_o <= 1'b0;
					else if (byte_end)
					begin
						bit_cnt_ff <= 4'h0;
						if (nack_ff)
						begin
							state_ff  <= ST_IDLE;
							data_oe_o <= 1'b0;
						end
						else
						begin
							shift_ff  <= tx_valid_i ? tx_data_i : IDLE_BYTE;
							data_oe_o <= tx_valid_i ? ~tx_data_i[7] : 1'b0;
						end
					end
				end
			endcase
		end
	end
endmodule : dpcio_front
`default_nettype wire

// ### logic/dpcio_pkg.sv
`default_nettype none
package dpcio_pkg;
	// ----------------------------------------------------------------
	// asynchronous character timing
	// ----------------------------------------------------------------
	localparam int unsigned ETU_CLKS      = 372;
	localparam int unsigned ETU_W         = 9;
	localparam logic [8:0]  ETU_LAST      = 9'(ETU_CLKS - 1);
	localparam logic [3:0]  CHAR_START    = 4'h0;
	localparam logic [3:0]  CHAR_PARITY   = 4'h9;
	localparam logic [3:0]  CHAR_LAST     = 4'hB;
	localparam logic [2:0]  ATR_LAST_BYTE = 3'h7;
	localparam int unsigned ATR_BITS      = 64;

	// ----------------------------------------------------------------
	// two-wire bus framing
	// ----------------------------------------------------------------
	localparam logic [3:0]  BIT_ACK       = 4'h8;
	localparam logic [3:0]  BIT_END       = 4'h9;
	localparam int unsigned ADDR_MSB      = 7;
	localparam int unsigned ADDR_LSB      = 4;
	localparam int unsigned RW_BIT        = 0;
	localparam logic [3:0]  ADDR_NONE     = 4'h0;
	localparam logic [7:0]  IDLE_BYTE     = 8'hFF;

	// ----------------------------------------------------------------
	// pin synchroniser lanes
	// ----------------------------------------------------------------
	localparam int unsigned PIN_N         = 4;
	localparam int unsigned PIN_CLK       = 0;
	localparam int unsigned PIN_DAT       = 1;
	localparam int unsigned PIN_RST       = 2;
	localparam int unsigned PIN_MODE      = 3;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CMD,
		ST_WR,
		ST_RD,
		ST_ATR
	} dpcio_state_t;
endpackage : dpcio_pkg
`default_nettype wire

// ### sim/dpcio_front_props.sv
`default_nettype none
module dpcio_front_props
(
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic       link_clk_i,
	input wire logic       card_rst_i,
	input wire logic       mode_async_i,
	input wire logic       tx_valid_i,
	input wire logic       tx_ready_o,
	input wire logic [7:0] rx_data_o,
	input wire logic       rx_valid_o,
	input wire logic       rx_ready_i,
	input wire logic       data_o,
	input wire logic       data_oe_o,
	input wire logic       rst_pull_en_o
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	chk_never_high:
		assert property (data_o == 1'b0) else $error("data driven high");
	chk_pull_kept:
		assert property (rst_pull_en_o == 1'b1) else $error("reset pull-up off");
	chk_fall_only:
		assert property (!mode_async_i && !$past(mode_async_i, 4) && $changed(data_oe_o)
			|-> !link_clk_i) else $error("data moved with clock high");
	chk_answer_start:
		assert property (mode_async_i && $past(mode_async_i, 4) && $rose(card_rst_i)
			|-> ##[2:6] data_oe_o) else $error("no start bit");
	chk_ack_hold:
		assert property (!mode_async_i && $rose(data_oe_o) |-> data_oe_o [*6])
			else $error("pull too short");
	chk_rx_hold:
		assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
			else $error("rx word lost");
	chk_tx_cause:
		assert property (tx_ready_o |-> tx_valid_i && !mode_async_i) else $error("bad take");
	chk_tx_pulse:
		assert property (tx_ready_o |=> !tx_ready_o) else $error("take too long");
endmodule : dpcio_front_props
bind dpcio_front dpcio_front_props dpcio_front_props_i (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .link_clk_i(link_clk_i), .card_rst_i(card_rst_i),
	.mode_async_i(mode_async_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
	.rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
	.data_o(data_o), .data_oe_o(data_oe_o), .rst_pull_en_o(rst_pull_en_o));
`default_nettype wire

// ### sim/dpcio_host.sv
`default_nettype none
module dpcio_host
(
	input  wire logic sys_clk,
	input  wire logic data_oe_o,
	output var logic  link_clk_i,
	output var logic  card_rst_i,
	output wire logic data_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic host_low = 1'b0;
	logic free_run = 1'b0;
	initial link_clk_i = 1'b1;
	initial card_rst_i = 1'b1;
	assign data_i = !(data_oe_o || host_low);
	always
	begin
		wait (free_run);
		#337;
		while (free_run)
		begin
			link_clk_i = ~link_clk_i;
			#400;
		end
	end
	task automatic wt(input int c);
		repeat (c) @(posedge sys_clk);
		#5;
	endtask : wt
	task automatic rst_pulse;
		card_rst_i = 1'b0;
		wt(8);
		card_rst_i = 1'b1;
		wt(8);
	endtask : rst_pulse
	task automatic start_c;
		host_low = 1'b0;
		wt(8);
		link_clk_i = 1'b1;
		wt(8);
		host_low = 1'b1;
		wt(8);
		link_clk_i = 1'b0;
	endtask : start_c
	task automatic stop_c;
		wt(4);
		host_low = 1'b1;
		wt(4);
		link_clk_i = 1'b1;
		wt(8);
		host_low = 1'b0;
		wt(8);
	endtask : stop_c
	// byte plus ack bit, data moved mid-low
	task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
		output logic ack);
		logic [8:0] s;
		for (int i = 8; i >= 0; i--)
		begin
			wt(4);
			host_low = i > 0 ? !tx[i - 1] : mack;
			wt(4);
			link_clk_i = 1'b1;
			wt(8);
			s[i] = data_i;
			link_clk_i = 1'b0;
		end
		rx = s[8:1];
		ack = !s[0];
	endtask : xfer
endmodule : dpcio_host
`default_nettype wire

// ### sim/dual_protocol_card_io_front_tb_top.sv
`default_nettype none
module dual_protocol_card_io_front_tb_top import dpcio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk, sys_rst, mode_async_i, tx_valid_i, rx_ready_i, k;
	logic        link_clk_i, card_rst_i, data_i, tx_ready_o, rx_valid_o;
	logic        data_o, data_oe_o, rst_pull_en_o;
	logic [3:0]  dev_addr_i;
	logic [63:0] atr_value_i;
	logic [7:0]  tx_data_i, rx_data_o, r;
	logic [7:0]  d [3];
	int          num_errors, total_checks, seed, n, takes;
	dpcio_front dpcio_front_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .link_clk_i(link_clk_i),
		.card_rst_i(card_rst_i), .data_i(data_i), .mode_async_i(mode_async_i),
		.dev_addr_i(dev_addr_i), .atr_value_i(atr_value_i), .tx_data_i(tx_data_i),
		.tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o),
		.rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .data_o(data_o),
		.data_oe_o(data_oe_o), .rst_pull_en_o(rst_pull_en_o));
	dpcio_host dpcio_host_i (.sys_clk(sys_clk), .data_oe_o(data_oe_o),
		.link_clk_i(link_clk_i), .card_rst_i(card_rst_i), .data_i(data_i));
	function automatic logic [7:0] cmd_byte(input logic [3:0] a, input logic rd);
		return {a, 3'h0, rd};
	endfunction : cmd_byte
	// pull enable over the first two characters, first data bit of byte 0 at index 0
	function automatic logic char_oe(input logic [63:0] v, input int i);
		logic [23:0] lvl;
		lvl = {2'b11, ^v[15:8], v[15:8], 1'b0, 2'b11, ^v[7:0], v[7:0], 1'b0};
		return !lvl[i + 1];
	endfunction : char_oe
	task automatic cmp1(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("FAIL %s exp %h got %h", what, exp, got);
		end
	endtask : cmp1
	task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("FAIL %s exp %h got %h", what, exp, got);
		end
	endtask : cmp8
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// counts one-cycle take pulses, sampled where settled
	always @(negedge sys_clk) takes += (tx_ready_o === 1'b1);
	initial
	begin
		#8000000;
		num_errors++;
		final_report();
	end
	initial
	begin
		seed = 32'h985E231D;
		sys_rst = 1'b1;
		{mode_async_i, tx_valid_i, rx_ready_i, tx_data_i} = 11'h000;
		dev_addr_i = 4'({$random(seed)} % 15 + 1);
		atr_value_i = {$random(seed), $random(seed)} | 64'h1;
		repeat (8) @(posedge sys_clk);
		#5 sys_rst = 1'b0;
		dpcio_host_i.wt(4);
		dpcio_host_i.start_c();
		dpcio_host_i.xfer(cmd_byte(dev_addr_i, 1'b0), 1'b0, r, k);
		cmp1("write cmd ack", 1'b1, k);
		for (int j = 0; j < 3; j++)
		begin
			d[j] = 8'($random(seed));
			dpcio_host_i.xfer(d[j], 1'b0, r, k);
			cmp1("write ack", j < 2, k);
		end
		dpcio_host_i.stop_c();
		for (int j = 0; j < 2; j++)
		begin
			cmp8("rx data", d[j], rx_data_o);
			rx_ready_i = 1'b1;
			dpcio_host_i.wt(1);
			rx_ready_i = 1'b0;
			dpcio_host_i.wt(1);
		end
		cmp1("rx empty", 1'b0, rx_valid_o);
		dpcio_host_i.start_c();
		dpcio_host_i.xfer(cmd_byte(4'(dev_addr_i % 15 + 1), 1'b0), 1'b0, r, k);
		cmp1("foreign ack", 1'b0, k);
		dpcio_host_i.stop_c();
		for (int j = 0; j < 2; j++)
		begin
			tx_data_i = 8'($random(seed));
			tx_valid_i = (j == 0);
			n = takes;
			dpcio_host_i.start_c();
			dpcio_host_i.xfer(cmd_byte(dev_addr_i, 1'b1), 1'b0, r, k);
			cmp1("read cmd ack", 1'b1, k);
			dpcio_host_i.xfer(8'hFF, 1'b0, r, k);
			cmp8("read data", j == 0 ? tx_data_i : 8'hFF, r);
			dpcio_host_i.stop_c();
			cmp8("tx takes", j == 0 ? 8'h01 : 8'h00, 8'(takes - n));
		end
		tx_valid_i = 1'b0;
		dpcio_host_i.rst_pulse();
		n = 0;
		repeat (200)
		begin
			dpcio_host_i.wt(1);
			n += (data_oe_o !== 1'b0);
		end
		cmp1("two-wire answer", 1'b0, n != 0);
		mode_async_i = 1'b1;
		dpcio_host_i.free_run = 1'b1;
		dpcio_host_i.wt(8);
		dpcio_host_i.rst_pulse();
		cmp1("start bit", 1'b1, data_oe_o);
		n = 0;
		while (data_oe_o === 1'b1 && n < 400)
		begin
			@(posedge link_clk_i);
			n++;
		end
		cmp1("bit time", 1'b1, n >= ETU_CLKS - 1 && n <= ETU_CLKS + 2);
		repeat (ETU_CLKS / 2) @(posedge link_clk_i);
		for (int i = 0; i < 13; i++)
		begin
			cmp1("char bit", char_oe(atr_value_i, i), data_oe_o);
			repeat (ETU_CLKS) @(posedge link_clk_i);
		end
		dpcio_host_i.free_run = 1'b0;
		final_report();
	end
endmodule : dual_protocol_card_io_front_tb_top
`default_nettype wire
